// *** bsfu_pkg.sv ***
/*
 * bsfu_pkg: constants and types for the bit, shift and flag unit.
 * assumes: an 8-bit core with an 8-bit status register and a 6-bit I/O address space.
 */
`default_nettype none

package bsfu_pkg;

	localparam int unsigned DATA_W   = 8;
	localparam int unsigned IDX_W    = 3;
	localparam int unsigned IOA_W    = 6;

	// status register bit positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_T = 3'h6;

	localparam logic [7:0] STATUS_REGISTER_RESET = 8'h00;
	localparam logic [7:0] DATA_ZERO  = 8'h00;
	localparam logic [5:0] IOA_ZERO   = 6'h00;
	localparam logic [4:0] REG_ZERO   = 5'h00;
	localparam int unsigned MSB       = 7;
	localparam int unsigned NIB       = 4;

	// operation codes
	typedef enum logic [4:0] {
		BSFU_OP_NONE       = 5'h00,
		BSFU_OP_PUSH       = 5'h01,
		BSFU_OP_POP        = 5'h02,
		BSFU_OP_IO_SET     = 5'h03,
		BSFU_OP_IO_CLR     = 5'h04,
		BSFU_OP_LSL        = 5'h05,
		BSFU_OP_LSR        = 5'h06,
		BSFU_OP_ROL        = 5'h07,
		BSFU_OP_ROR        = 5'h08,
		BSFU_OP_ASR        = 5'h09,
		BSFU_OP_NIBBLE     = 5'h0A,
		BSFU_OP_FLAG_SET   = 5'h0B,
		BSFU_OP_FLAG_CLR   = 5'h0C,
		BSFU_OP_TO_T       = 5'h0D,
		BSFU_OP_FROM_T     = 5'h0E,
		BSFU_OP_CARRY_SET  = 5'h0F
	} bsfu_op_t;

endpackage

`default_nettype wire

// *** bsfu_shifter.sv ***
/*
 * bsfu_shifter: combinational shift, rotate and nibble exchange with
 * the flag results of each.
 * assumes: operand and carry come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module bsfu_shifter #(
	parameter int unsigned W = bsfu_pkg::DATA_W
) (
	// operation
	input  wire logic            lsl_i,
	input  wire logic            lsr_i,
	input  wire logic            rol_i,
	input  wire logic            ror_i,
	input  wire logic            asr_i,
	input  wire logic            nib_i,
	// operand
	input  wire logic [W-1:0]    opnd_i,
	input  wire logic            carry_i,
	// result
	output logic      [W-1:0]    res_o,
	output logic                 c_o,
	output logic                 z_o,
	output logic                 n_o,
	output logic                 v_o,
	output logic                 s_o
);

	localparam int unsigned H = W / 2;

	always_comb begin
		res_o = opnd_i;
		c_o   = carry_i;
		if (lsl_i) begin
			res_o = {opnd_i[W-2:0], 1'b0};
			c_o   = opnd_i[W-1];
		end else if (lsr_i) begin
			res_o = {1'b0, opnd_i[W-1:1]};
			c_o   = opnd_i[0];
		end else if (rol_i) begin
			res_o = {opnd_i[W-2:0], carry_i};
			c_o   = opnd_i[W-1];
		end else if (ror_i) begin
			res_o = {carry_i, opnd_i[W-1:1]};
			c_o   = opnd_i[0];
		end else if (asr_i) begin
			res_o = {opnd_i[W-1], opnd_i[W-1:1]};
			c_o   = opnd_i[0];
		end else if (nib_i) begin
			res_o = {opnd_i[H-1:0], opnd_i[W-1:H]};
		end
		z_o = (res_o == '0);
		n_o = res_o[W-1];
		v_o = n_o ^ c_o;
		s_o = n_o ^ v_o;
	end

endmodule

`default_nettype wire

// *** bsfu_core.sv ***
/*
 * bsfu_core: execution unit for push/pop, I/O bit set and clear,
 * shifts and rotates, nibble exchange, status flag operations and
 * transfer-flag moves. Holds the status register itself.
 * assumes: decode supplies a one-cycle op strobe with operands read
 * from the register file, stack and I/O space in the same cycle;
 * results are registered and shown one cycle later with write strobes.
 * back-to-back ops need the caller to forward the previous write.
 * op codes 10-1F are refused: no write, no flag change, no done.
 */
// Overview of operation
// - Push writes the source register to the stack; pop loads the destination register from the stack.
// - I/O bit set forces the addressed bit to one, bit clear to zero, other bits untouched.
// - Logical left shift moves bits up and loads zero into bit 0.
// - Logical right shift moves bits down and loads zero into bit 7.
// - Rotate left puts old carry in bit 0 and old bit 7 into carry.
// - Rotate right puts old carry in bit 7 and old bit 0 into carry.
// - Arithmetic right shift moves bits down while bit 7 keeps its value.
// - Nibble exchange swaps the upper and lower four bits.
// - Flag set forces the selected status bit to one, flag clear to zero.
// - Bit store copies the selected source bit into the transfer flag.
// - Bit load copies the transfer flag into the selected destination bit only.
// - Set carry forces the carry flag to one and changes nothing else.
`timescale 1ns/1ps
`default_nettype none

module bsfu_core #(
	parameter int unsigned W     = bsfu_pkg::DATA_W,
	parameter int unsigned IOA_W = bsfu_pkg::IOA_W
) (
	// clock and reset
	input  wire logic                ref_clk_i,
	input  wire logic                reset_n_i,
	// operation request
	input  wire logic                op_valid_i,
	input  wire bsfu_pkg::bsfu_op_t  op_i,
	input  wire logic [4:0]          reg_sel_i,
	input  wire logic [2:0]          bit_sel_i,
	input  wire logic [IOA_W-1:0]    io_addr_i,
	// operands
	input  wire logic [W-1:0]        reg_rdata_i,
	input  wire logic [W-1:0]        stack_rdata_i,
	input  wire logic [W-1:0]        io_rdata_i,
	// register file write
	output logic                     reg_we_o,
	output logic      [4:0]          reg_waddr_o,
	output logic      [W-1:0]        reg_wdata_o,
	// stack
	output logic                     stack_push_o,
	output logic                     stack_pop_o,
	output logic      [W-1:0]        stack_wdata_o,
	// I/O space write
	output logic                     io_we_o,
	output logic      [IOA_W-1:0]    io_waddr_o,
	output logic      [W-1:0]        io_wdata_o,
	// status register
	output logic      [W-1:0]        status_register_o,
	output logic                     done_o
);

	////////////////////////////////////////////////////////////////////
	// decode

	logic is_lsl;
	logic is_lsr;
	logic is_rol;
	logic is_ror;
	logic is_asr;
	logic is_nib;
	logic is_shift;
	logic [W-1:0] bit_mask;

	assign is_lsl   = op_valid_i && (op_i == bsfu_pkg::BSFU_OP_LSL);
	assign is_lsr   = op_valid_i && (op_i == bsfu_pkg::BSFU_OP_LSR);
	assign is_rol   = op_valid_i && (op_i == bsfu_pkg::BSFU_OP_ROL);
	assign is_ror   = op_valid_i && (op_i == bsfu_pkg::BSFU_OP_ROR);
	assign is_asr   = op_valid_i && (op_i == bsfu_pkg::BSFU_OP_ASR);
	assign is_nib   = op_valid_i && (op_i == bsfu_pkg::BSFU_OP_NIBBLE);
	assign is_shift = is_lsl | is_lsr | is_rol | is_ror | is_asr;

	// one-hot mask of the addressed bit
	for (genvar gi = 0; gi < W; gi++) begin : g_mask
		assign bit_mask[gi] = (bit_sel_i == 3'(gi));
	end

	////////////////////////////////////////////////////////////////////
	// shifter

	logic [W-1:0] sh_res;
	logic         sh_c;
	logic         sh_z;
	logic         sh_n;
	logic         sh_v;
	logic         sh_s;
	logic [W-1:0] status_register_q;
	logic [W-1:0] status_register_d;

	// rotates read the registered carry, current for back-to-back ops
	bsfu_shifter #(
		.W (W)
	) u_shifter (
		.lsl_i   (is_lsl),
		.lsr_i   (is_lsr),
		.rol_i   (is_rol),
		.ror_i   (is_ror),
		.asr_i   (is_asr),
		.nib_i   (is_nib),
		.opnd_i  (reg_rdata_i),
		.carry_i (status_register_q[bsfu_pkg::FLAG_C]),
		.res_o   (sh_res),
		.c_o     (sh_c),
		.z_o     (sh_z),
		.n_o     (sh_n),
		.v_o     (sh_v),
		.s_o     (sh_s)
	);

	////////////////////////////////////////////////////////////////////
	// next state

	logic             reg_we_q;
	logic             reg_we_d;
	logic [4:0]       reg_waddr_q;
	logic [4:0]       reg_waddr_d;
	logic [W-1:0]     reg_wdata_q;
	logic [W-1:0]     reg_wdata_d;
	logic             push_q;
	logic             push_d;
	logic             pop_q;
	logic             pop_d;
	logic [W-1:0]     stack_wdata_q;
	logic [W-1:0]     stack_wdata_d;
	logic             io_we_q;
	logic             io_we_d;
	logic [IOA_W-1:0] io_waddr_q;
	logic [IOA_W-1:0] io_waddr_d;
	logic [W-1:0]     io_wdata_q;
	logic [W-1:0]     io_wdata_d;
	logic             done_q;
	logic             done_d;

	// addresses and data hold their last value between ops
	always_comb begin
		status_register_d = status_register_q;
		reg_we_d      = 1'b0;
		reg_waddr_d   = reg_waddr_q;
		reg_wdata_d   = reg_wdata_q;
		push_d        = 1'b0;
		pop_d         = 1'b0;
		stack_wdata_d = stack_wdata_q;
		io_we_d       = 1'b0;
		io_waddr_d    = io_waddr_q;
		io_wdata_d    = io_wdata_q;
		// refused codes land in default and raise no done
		done_d        = op_valid_i && (op_i != bsfu_pkg::BSFU_OP_NONE);
		if (op_valid_i) begin
			unique case (op_i)
				bsfu_pkg::BSFU_OP_NONE: begin
				end
				bsfu_pkg::BSFU_OP_PUSH: begin
					push_d        = 1'b1;
					stack_wdata_d = reg_rdata_i;
				end
				bsfu_pkg::BSFU_OP_POP: begin
					pop_d       = 1'b1;
					reg_we_d    = 1'b1;
					reg_waddr_d = reg_sel_i;
					reg_wdata_d = stack_rdata_i;
				end
				bsfu_pkg::BSFU_OP_IO_SET: begin
					io_we_d    = 1'b1;
					io_waddr_d = io_addr_i;
					io_wdata_d = io_rdata_i | bit_mask;
				end
				bsfu_pkg::BSFU_OP_IO_CLR: begin
					io_we_d    = 1'b1;
					io_waddr_d = io_addr_i;
					io_wdata_d = io_rdata_i & ~bit_mask;
				end
				bsfu_pkg::BSFU_OP_LSL,
				bsfu_pkg::BSFU_OP_LSR,
				bsfu_pkg::BSFU_OP_ROL,
				bsfu_pkg::BSFU_OP_ROR,
				bsfu_pkg::BSFU_OP_ASR,
				bsfu_pkg::BSFU_OP_NIBBLE: begin
					reg_we_d    = 1'b1;
					reg_waddr_d = reg_sel_i;
					reg_wdata_d = sh_res;
					if (is_shift) begin
						status_register_d[bsfu_pkg::FLAG_C] = sh_c;
						status_register_d[bsfu_pkg::FLAG_Z] = sh_z;
						status_register_d[bsfu_pkg::FLAG_N] = sh_n;
						status_register_d[bsfu_pkg::FLAG_V] = sh_v;
						status_register_d[bsfu_pkg::FLAG_S] = sh_s;
					end
				end
				bsfu_pkg::BSFU_OP_FLAG_SET: begin
					status_register_d = status_register_q | bit_mask;
				end
				bsfu_pkg::BSFU_OP_FLAG_CLR: begin
					status_register_d = status_register_q & ~bit_mask;
				end
				bsfu_pkg::BSFU_OP_TO_T: begin
					status_register_d[bsfu_pkg::FLAG_T] =
						reg_rdata_i[bit_sel_i];
				end
				bsfu_pkg::BSFU_OP_FROM_T: begin
					reg_we_d    = 1'b1;
					reg_waddr_d = reg_sel_i;
					reg_wdata_d = status_register_q[bsfu_pkg::FLAG_T]
						? (reg_rdata_i | bit_mask)
						: (reg_rdata_i & ~bit_mask);
				end
				bsfu_pkg::BSFU_OP_CARRY_SET: begin
					status_register_d[bsfu_pkg::FLAG_C] = 1'b1;
				end
				default: begin
					done_d = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers

	// register file write strobe, address and data
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_we_q    <= 1'b0;
			reg_waddr_q <= bsfu_pkg::REG_ZERO;
			reg_wdata_q <= bsfu_pkg::DATA_ZERO;
		end else begin
			reg_we_q    <= reg_we_d;
			reg_waddr_q <= reg_waddr_d;
			reg_wdata_q <= reg_wdata_d;
		end
	end

	// stack strobes and push data
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			push_q        <= 1'b0;
			pop_q         <= 1'b0;
			stack_wdata_q <= bsfu_pkg::DATA_ZERO;
		end else begin
			push_q        <= push_d;
			pop_q         <= pop_d;
			stack_wdata_q <= stack_wdata_d;
		end
	end

	// I/O write strobe, address and data
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			io_we_q    <= 1'b0;
			io_waddr_q <= bsfu_pkg::IOA_ZERO;
			io_wdata_q <= bsfu_pkg::DATA_ZERO;
		end else begin
			io_we_q    <= io_we_d;
			io_waddr_q <= io_waddr_d;
			io_wdata_q <= io_wdata_d;
		end
	end

	// status register and completion pulse
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_register_q <= bsfu_pkg::STATUS_REGISTER_RESET;
			done_q            <= 1'b0;
		end else begin
			status_register_q <= status_register_d;
			done_q            <= done_d;
		end
	end

	assign status_register_o = status_register_q;
	assign reg_we_o          = reg_we_q;
	assign reg_waddr_o       = reg_waddr_q;
	assign reg_wdata_o       = reg_wdata_q;
	assign stack_push_o      = push_q;
	assign stack_pop_o       = pop_q;
	assign stack_wdata_o     = stack_wdata_q;
	assign io_we_o           = io_we_q;
	assign io_waddr_o        = io_waddr_q;
	assign io_wdata_o        = io_wdata_q;
	assign done_o            = done_q;

endmodule

`default_nettype wire

// *** bsfu_monitor.sv ***
/* bsfu_monitor: port assertions for bsfu_core.
   assumes: bound to bsfu_core, one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module bsfu_monitor (
	// clock, reset and request
	input wire logic               ref_clk_i,
	input wire logic               reset_n_i,
	input wire logic               op_valid_i,
	input wire bsfu_pkg::bsfu_op_t op_i,
	input wire logic [2:0]         bit_sel_i,
	// operands
	input wire logic [7:0]         reg_rdata_i,
	input wire logic [7:0]         stack_rdata_i,
	input wire logic [7:0]         io_rdata_i,
	// results
	input wire logic               reg_we_o,
	input wire logic [7:0]         reg_wdata_o,
	input wire logic               stack_push_o,
	input wire logic               stack_pop_o,
	input wire logic [7:0]         stack_wdata_o,
	input wire logic               io_we_o,
	input wire logic [7:0]         io_wdata_o,
	input wire logic [7:0]         status_register_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// code of the op taken at this edge, none when idle
	wire logic [4:0] op_act = op_valid_i ? op_i : 5'h00;
	logic      [7:0] rd_q;
	logic      [7:0] sr_q;
	always_ff @(posedge ref_clk_i) begin
		rd_q <= reg_rdata_i;
		sr_q <= status_register_o;
	end
	////////////////////////////////////////////////////////////////////
	property p_push;
		op_act == 5'h01 |=> stack_push_o && stack_wdata_o == rd_q;
	endproperty
	a_push: assert property (p_push) else $error("push byte wrong");
	property p_pop;
		op_act == 5'h02 |=> stack_pop_o && reg_we_o
			&& reg_wdata_o == $past(stack_rdata_i)
			##1 stack_pop_o == ($past(op_act) == 5'h02);
	endproperty
	a_pop: assert property (p_pop) else $error("pop load wrong");
	property p_ioset;
		op_act == 5'h03 |=> io_we_o
			&& io_wdata_o == ($past(io_rdata_i) | (8'h01 << $past(bit_sel_i)));
	endproperty
	a_ioset: assert property (p_ioset) else $error("io set wrong");
	property p_rol;
		op_act == 5'h07 |=> reg_wdata_o == {rd_q[6:0], sr_q[0]}
			&& status_register_o[0] == rd_q[7];
	endproperty
	a_rol: assert property (p_rol) else $error("rotate left wrong");
	property p_asr;
		op_act == 5'h09 |=> reg_wdata_o == {rd_q[7], rd_q[7:1]};
	endproperty
	a_asr: assert property (p_asr) else $error("sign shift wrong");
	property p_nib;
		op_act == 5'h0A |=> reg_wdata_o == {rd_q[3:0], rd_q[7:4]}
			&& $stable(status_register_o);
	endproperty
	a_nib: assert property (p_nib) else $error("nibble swap wrong");
	property p_keep;
		op_act inside {5'h01, 5'h02, 5'h03, 5'h04} |=> $stable(status_register_o);
	endproperty
	a_keep: assert property (p_keep) else $error("flags disturbed");
	property p_sec;
		op_act == 5'h0F |=> status_register_o == (sr_q | 8'h01);
	endproperty
	a_sec: assert property (p_sec) else $error("carry set wrong");
endmodule
`default_nettype wire

// *** bsfu_mem.sv ***
/* bsfu_mem: register file, stack and I/O space around bsfu_core.
   assumes: the bench preloads cells before any op reads them. */
`timescale 1ns/1ps
`default_nettype none
module bsfu_mem (
	// clock and read side
	input wire logic        ref_clk_i,
	input wire logic [4:0]  reg_sel_i,
	input wire logic [5:0]  io_addr_i,
	output logic     [7:0]  reg_rdata_o,
	output logic     [7:0]  stack_rdata_o,
	output logic     [7:0]  io_rdata_o,
	// write side
	input wire logic        reg_we_i,
	input wire logic [4:0]  reg_waddr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        stack_push_i,
	input wire logic        stack_pop_i,
	input wire logic [7:0]  stack_wdata_i,
	input wire logic        io_we_i,
	input wire logic [5:0]  io_waddr_i,
	input wire logic [7:0]  io_wdata_i
);
	logic [7:0] regs [32];
	logic [7:0] io [64];
	logic [7:0] stk [8];
	logic [2:0] sp = 3'h0;
	assign reg_rdata_o = regs[reg_sel_i];
	assign io_rdata_o = io[io_addr_i];
	assign stack_rdata_o = stk[sp];
	always @(posedge ref_clk_i) begin
		if (reg_we_i)
			regs[reg_waddr_i] <= reg_wdata_i;
		if (io_we_i)
			io[io_waddr_i] <= io_wdata_i;
		if (stack_push_i) begin
			stk[sp + 3'h1] <= stack_wdata_i;
			sp <= sp + 3'h1;
		end
		if (stack_pop_i)
			sp <= sp - 3'h1;
	end
endmodule
`default_nettype wire

// *** bsfu_core_tb.sv ***
/* bsfu_core_tb: self-checking bench for bsfu_core.
   assumes: bsfu_mem stands in for register file, stack and I/O. */
`timescale 1ns/1ps
`default_nettype none
module bsfu_core_tb;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic op_valid_i = 1'b0;
	bsfu_pkg::bsfu_op_t op_i = bsfu_pkg::BSFU_OP_NONE;
	logic [4:0] reg_sel_i = 5'h00;
	logic [2:0] bit_sel_i = 3'h0;
	logic [7:0] reg_rdata_i, stack_rdata_i, io_rdata_i, sr = 8'h00;
	logic [7:0] reg_wdata_o, stack_wdata_o, io_wdata_o, status_register_o;
	logic [4:0] reg_waddr_o;
	logic [5:0] io_waddr_o;
	logic reg_we_o, stack_push_o, stack_pop_o, io_we_o, done_o;
	int error_cnt = 0;
	int n_tests = 0;
	always #10 ref_clk_i = ~ref_clk_i;
	bsfu_core u_dut (.ref_clk_i, .reset_n_i, .op_valid_i, .op_i, .reg_sel_i,
		.bit_sel_i, .io_addr_i({1'b0, reg_sel_i}), .reg_rdata_i,
		.stack_rdata_i, .io_rdata_i, .reg_we_o, .reg_waddr_o, .reg_wdata_o,
		.stack_push_o, .stack_pop_o, .stack_wdata_o, .io_we_o, .io_waddr_o,
		.io_wdata_o, .status_register_o, .done_o);
	bsfu_mem u_mem (.ref_clk_i, .reg_sel_i, .io_addr_i({1'b0, reg_sel_i}),
		.reg_rdata_o(reg_rdata_i), .stack_rdata_o(stack_rdata_i),
		.io_rdata_o(io_rdata_i), .reg_we_i(reg_we_o),
		.reg_waddr_i(reg_waddr_o), .reg_wdata_i(reg_wdata_o),
		.stack_push_i(stack_push_o), .stack_pop_i(stack_pop_o),
		.stack_wdata_i(stack_wdata_o), .io_we_i(io_we_o),
		.io_waddr_i(io_waddr_o), .io_wdata_i(io_wdata_o));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [8:0] e, g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// one op, then results seen in the answer cycle
	task automatic do_op(input logic [4:0] op, r, input logic [2:0] b);
		@(negedge ref_clk_i);
		op_valid_i = 1'b1;
		op_i = bsfu_pkg::bsfu_op_t'(op);
		reg_sel_i = r;
		bit_sel_i = b;
		@(negedge ref_clk_i);
		op_valid_i = 1'b0;
		chk("status", {1'b0, sr}, {1'b0, status_register_o});
		chk("done", {8'h00, op inside {[5'h01:5'h0F]}}, {8'h00, done_o});
	endtask
	task automatic t_shift(input logic [7:0] v);
		logic [8:0] x;
		logic vv;
		for (int k = 5; k <= 10; k++) begin
			// let the previous result land before the operand is preset
			@(negedge ref_clk_i);
			u_mem.regs[3] = v;
			case (k)
				5: x = {v, 1'b0};
				6: x = {v[0], 1'b0, v[7:1]};
				7: x = {v, sr[0]};
				8: x = {v[0], sr[0], v[7:1]};
				9: x = {v[0], v[7], v[7:1]};
				default: x = {sr[0], v[3:0], v[7:4]};
			endcase
			vv = x[7] ^ x[8];
			if (k != 10)
				sr[4:0] = {x[7] ^ vv, vv, x[7], x[7:0] == 8'h00, x[8]};
			do_op(k[4:0], 5'h03, 3'h0);
			chk("shift", {1'b1, x[7:0]}, {reg_we_o, reg_wdata_o});
			chk("shift addr", 9'h003, {4'h0, reg_waddr_o});
		end
	endtask
	task automatic t_move;
		u_mem.regs[1] = 8'hA5;
		u_mem.io[9] = 8'h5A;
		do_op(5'h01, 5'h01, 3'h0);
		chk("push", 9'h1A5, {stack_push_o, stack_wdata_o});
		do_op(5'h02, 5'h02, 3'h0);
		chk("pop", 9'h1A5, {stack_pop_o & reg_we_o, reg_wdata_o});
		chk("pop addr", 9'h002, {4'h0, reg_waddr_o});
		do_op(5'h03, 5'h09, 3'h7);
		chk("io set", 9'h1DA, {io_we_o, io_wdata_o});
		chk("io addr", 9'h009, {3'h0, io_waddr_o});
		do_op(5'h04, 5'h09, 3'h1);
		chk("io clear", 9'h1D8, {io_we_o, io_wdata_o});
		do_op(5'h10, 5'h09, 3'h0);
		do_op(5'h00, 5'h09, 3'h0);
	endtask
	task automatic t_flags;
		for (int b = 0; b < 8; b++) begin
			sr[b] = 1'b1;
			do_op(5'h0B, 5'h00, b[2:0]);
			sr[b] = 1'b0;
			do_op(5'h0C, 5'h00, b[2:0]);
		end
		u_mem.regs[5] = 8'h40;
		sr[6] = 1'b1;
		do_op(5'h0D, 5'h05, 3'h6);
		chk("store we", 9'h000, {8'h00, reg_we_o});
		u_mem.regs[5] = 8'h81;
		do_op(5'h0E, 5'h05, 3'h2);
		chk("bit load", 9'h185, {reg_we_o, reg_wdata_o});
		sr[0] = 1'b1;
		do_op(5'h0F, 5'h00, 3'h0);
		chk("carry we", 9'h000, {8'h00, reg_we_o});
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		reset_n_i = 1'b1;
		t_shift(8'h81);
		t_shift(8'h00);
		t_shift(8'h7E);
		t_move();
		t_flags();
		print_verdict();
	end
	initial begin
		repeat (2000) @(posedge ref_clk_i);
		error_cnt++;
		print_verdict();
	end
endmodule
bind bsfu_core bsfu_monitor u_mon (.ref_clk_i, .reset_n_i, .op_valid_i,
	.op_i, .bit_sel_i, .reg_rdata_i, .stack_rdata_i, .io_rdata_i, .reg_we_o,
	.reg_wdata_o, .stack_push_o, .stack_pop_o, .stack_wdata_o, .io_we_o,
	.io_wdata_o, .status_register_o);
`default_nettype wire
